// file: verilog/motion_config_consts.vh
`ifndef MOTION_CONFIG_CONSTS_VH
`define MOTION_CONFIG_CONSTS_VH

// setup word a field positions
`define CFG_A_MODE_BIT      15
`define CFG_A_ENC_EN_BIT    10
`define CFG_A_RSV_HI        9
`define CFG_A_RSV_LO        6
`define CFG_A_SEL_W         3

// setup word b field positions
`define CFG_B_READBACK_BIT  11
`define CFG_B_PERSIST_BIT   10
`define CFG_B_REPORT_BIT    9
`define CFG_B_COMMAND_BIT   8
`define CFG_B_ORDER_BIT     7
`define CFG_B_RSV1_HI       14
`define CFG_B_RSV1_LO       12
`define CFG_B_RSV2_HI       6
`define CFG_B_RSV2_LO       2

// input function selector codes
`define FN_GENERAL   3'h0
`define FN_CW_LIMIT  3'h1
`define FN_CCW_LIMIT 3'h2
`define FN_START_IDX 3'h3
`define FN_CTRL_STOP 3'h4
`define FN_ESTOP     3'h5
`define FN_HOME      3'h6
`define FN_INVALID   3'h7

// persist status codes in the last input word
`define PERSIST_OK   16'hAAAA
`define PERSIST_FAIL 16'hEEEE
`define WORD_ZERO    16'h0000

// reset values of the held setup words
`define CFG_A_RESET  16'h0000
`define CFG_B_RESET  16'h0003

// multi-word scale
`define MULTI_SCALE  32'sd1000

`endif

// file: verilog/word_format_codec.v
`timescale 1ns/10ps
`default_nettype none
`include "motion_config_consts.vh"

// converts one 32-bit signed value to and from its two network words
module word_format_codec (
  // format selection
  input  wire        i_fmt32,       // 1: signed 32-bit, 0: multi-word
  input  wire        i_big_endian,  // word order for 32-bit form
  // value to report
  input  wire [31:0] i_value,
  output wire [15:0] o_first,
  output wire [15:0] o_second,
  // words to interpret
  input  wire [15:0] i_first,
  input  wire [15:0] i_second,
  output wire [31:0] o_value
);

  // quotient and remainder truncate toward zero, so both keep the sign
  wire signed [31:0] quo   = $signed(i_value) / `MULTI_SCALE;
  wire signed [31:0] rem   = $signed(i_value) % `MULTI_SCALE;
  // out-of-range values simply wrap; the host must stay in range
  wire signed [31:0] multi = $signed({{16{i_first[15]}}, i_first})
                             * `MULTI_SCALE
                             + $signed({{16{i_second[15]}}, i_second});

  // report packing [RULE23] [RULE24]
  assign o_first  = !i_fmt32 ? quo[15:0] :
                    (i_big_endian ? i_value[31:16] : i_value[15:0]);
  assign o_second = !i_fmt32 ? rem[15:0] :
                    (i_big_endian ? i_value[15:0] : i_value[31:16]);

  // command unpacking [RULE23] [RULE24]
  assign o_value  = !i_fmt32 ? multi :
                    (i_big_endian ? {i_first, i_second}
                                  : {i_second, i_first});

endmodule
`default_nettype wire

// file: verilog/motion_config_word_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "motion_config_consts.vh"

// Summary of operation
// [RULE1] word a bit 10 enables built-in encoder
// [RULE2] host writes zero to word a bits 9-6
// [RULE3] selectors: input 2 bits 5-3, input 1 bits 2-0
// [RULE4] code 000: input only reported to host
// [RULE5] 001 clockwise limit, 010 counter-clockwise limit
// [RULE6] 011 rising starts index; changes capture encoder
// [RULE7] 100 stops jog or registration, captures encoder
// [RULE8] 101 rising edge halts all motion immediately
// [RULE9] 110 defines home position during homing
// [RULE10] code 111 reserved, treated as invalid
// [RULE11] word b bit 15 is ignored
// [RULE12] host writes zero to word b reserved bits
// [RULE13] readback bit on config entry returns held setup
// [RULE14] no new setup accepted while readback set
// [RULE15] word b bit 10 rising edge saves to flash
// [RULE16] invalid held setup: save edge ignored
// [RULE17] save success: last word AAAA, status flashes
// [RULE18] save failure: last word EEEE
// [RULE19] after a save, ignore all commands until reset
// [RULE20] bit 9 selects report format
// [RULE21] bit 8 selects command format
// [RULE22] bit 7 word order, only for 32-bit forms
// [RULE23] multi-word form: quotient by 1000, then remainder
// [RULE24] word order picks which half travels first
// [RULE25] invalid setup: stay in command mode, flag error
// [RULE26] edges found once from corrected successive samples
module motion_config_word_decoder #(
  parameter N_INPUTS = 2  // number of discrete inputs
) (
  // clock and reset
  input  wire                i_clk_sys,
  input  wire                i_rst_n,
  // network output words from the host
  input  wire                i_out_valid,    // one-cycle new-data strobe
  input  wire [15:0]         i_setup_word_a,
  input  wire [15:0]         i_setup_word_b,
  input  wire [15:0]         i_cmd_first,    // wide parameter, first word
  input  wire [15:0]         i_cmd_second,   // wide parameter, second word
  // discrete inputs, raw level
  input  wire [N_INPUTS-1:0] i_in_raw,
  // motion state to report
  input  wire [31:0]         i_motor_pos,
  input  wire [31:0]         i_encoder_pos,
  input  wire                i_homing,       // homing sequence running
  input  wire                i_jog_active,   // jog or registration move
  // flash port
  output wire                o_flash_req,    // one-cycle write request
  input  wire                i_flash_done,   // one-cycle completion
  input  wire                i_flash_ok,     // result with done
  // decoded setup
  output reg                 o_config_mode,
  output reg                 o_cfg_error,
  output reg                 o_encoder_en,
  output reg                 o_report_fmt32,
  output reg                 o_command_fmt32,
  output reg                 o_big_endian,
  output reg                 o_locked,
  output reg                 o_status_flash,
  // input functions
  output reg  [N_INPUTS-1:0] o_gp_state,
  output reg                 o_cw_limit,
  output reg                 o_ccw_limit,
  output reg                 o_start_index,  // pulse
  output reg                 o_ctrl_stop,    // pulse
  output reg                 o_emergency_stop, // pulse
  output reg                 o_home_event,   // pulse
  // network input words
  output reg  [15:0]         o_in_word_a,
  output reg  [15:0]         o_in_word_b,
  output reg  [15:0]         o_last_word,
  output reg  [15:0]         o_motor_first,
  output reg  [15:0]         o_motor_second,
  output reg  [15:0]         o_enc_first,
  output reg  [15:0]         o_enc_second,
  output reg  [15:0]         o_cap_first,
  output reg  [15:0]         o_cap_second,
  output reg  [31:0]         o_cmd_value
);

  // save sequence states
  localparam ST_IDLE = 2'b00;
  localparam ST_BUSY = 2'b01;
  localparam ST_DONE = 2'b10;

  reg  [15:0]         cfg_a;        // held setup word a
  reg  [15:0]         cfg_b;        // held setup word b
  reg                 persist_prev; // last seen save bit
  reg                 readback;     // mirroring held setup
  reg  [1:0]          save_state;
  reg  [1:0]          next_save_state;
  reg  [N_INPUTS-1:0] act_prev;     // corrected inputs, last cycle
  reg  [31:0]         captured;     // latched encoder position
  reg                 flash_req;

  wire enter_cfg = i_out_valid & i_setup_word_a[`CFG_A_MODE_BIT];
  wire [2:0] sel_new1 = i_setup_word_a[2:0];
  wire [2:0] sel_new2 = i_setup_word_a[5:3];

  // checks the incoming words before they are taken
  wire new_valid =
    (i_setup_word_a[`CFG_A_RSV_HI:`CFG_A_RSV_LO] == 4'h0) &&
    (i_setup_word_b[`CFG_B_RSV1_HI:`CFG_B_RSV1_LO] == 3'h0) &&
    (i_setup_word_b[`CFG_B_RSV2_HI:`CFG_B_RSV2_LO] == 5'h00) &&
    (sel_new1 != `FN_INVALID) && (sel_new2 != `FN_INVALID) && // [RULE10]
    ((sel_new1 != sel_new2) || (sel_new1 == `FN_GENERAL));

  // bit 15 of word b takes no part in any check [RULE11]
  wire held_valid =
    (cfg_a[`CFG_A_RSV_HI:`CFG_A_RSV_LO] == 4'h0) &&
    (cfg_a[2:0] != `FN_INVALID) && (cfg_a[5:3] != `FN_INVALID);

  // readback holds off new setup; lock holds off setup, save and readback
  wire take_new = enter_cfg & ~o_locked & ~readback
                  & ~i_setup_word_b[`CFG_B_READBACK_BIT];       // [RULE14]

  // save request on a clean 0 to 1 of the save bit
  wire persist_rise = i_out_valid & ~o_locked
                      & i_setup_word_b[`CFG_B_PERSIST_BIT]
                      & ~persist_prev;                          // [RULE15]
  wire save_go = persist_rise & held_valid & new_valid
                 & (save_state == ST_IDLE);                     // [RULE16]

  assign o_flash_req = flash_req;

  // per-input corrected level, edge terms and function decode
  wire [N_INPUTS-1:0] act;
  wire [N_INPUTS-1:0] rise;
  wire [N_INPUTS-1:0] chg;
  wire [N_INPUTS-1:0] is_cw;
  wire [N_INPUTS-1:0] is_ccw;
  wire [N_INPUTS-1:0] go_index;
  wire [N_INPUTS-1:0] go_stop;
  wire [N_INPUTS-1:0] go_estop;
  wire [N_INPUTS-1:0] go_home;
  wire [N_INPUTS-1:0] cap_hit;

  genvar gi;
  generate
    for (gi = 0; gi < N_INPUTS; gi = gi + 1) begin : g_in
      wire [2:0] sel = cfg_a[`CFG_A_SEL_W*gi +: `CFG_A_SEL_W]; // [RULE3]
      // active-level bit 1 means the raw level is the active level
      assign act[gi]  = i_in_raw[gi] ^ ~cfg_b[gi];
      assign rise[gi] = act[gi] & ~act_prev[gi];               // [RULE26]
      assign chg[gi]  = act[gi] ^ act_prev[gi];                // [RULE26]
      assign is_cw[gi]    = (sel == `FN_CW_LIMIT) & act[gi];   // [RULE5]
      assign is_ccw[gi]   = (sel == `FN_CCW_LIMIT) & act[gi];  // [RULE5]
      assign go_index[gi] = (sel == `FN_START_IDX) & rise[gi]; // [RULE6]
      assign go_stop[gi]  = (sel == `FN_CTRL_STOP) & rise[gi]
                            & i_jog_active;                    // [RULE7]
      assign go_estop[gi] = (sel == `FN_ESTOP) & rise[gi];     // [RULE8]
      assign go_home[gi]  = (sel == `FN_HOME) & rise[gi]
                            & i_homing;                        // [RULE9]
      // capture on any change for 011, on the stop itself for 100
      assign cap_hit[gi]  = o_encoder_en &
                            (((sel == `FN_START_IDX) & chg[gi]) |
                             go_stop[gi]);                     // [RULE6] [RULE7]
    end
  endgenerate

  // format codecs: motor, encoder, captured; first also unpacks commands
  wire [95:0] rep_vals = {captured, i_encoder_pos, i_motor_pos};
  wire [15:0] rep_first  [0:2];
  wire [15:0] rep_second [0:2];
  wire [31:0] cmd_unpacked;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_codec
      wire [31:0] unpack;
      word_format_codec u_codec (
        .i_fmt32      (gi == 0 ? o_command_fmt32 : o_report_fmt32),
        .i_big_endian (o_big_endian),
        .i_value      (rep_vals[32*gi +: 32]),
        .o_first      (rep_first[gi]),
        .o_second     (rep_second[gi]),
        .i_first      (i_cmd_first),
        .i_second     (i_cmd_second),
        .o_value      (unpack)
      );
      if (gi == 0) begin : g_cmd
        assign cmd_unpacked = unpack;
      end
    end
  endgenerate

  // the motor codec instance sees the command flag through slot 0, not the report flag
  wire [31:0] motor_rep_sel = i_motor_pos;
  wire signed [31:0] m_quo = $signed(motor_rep_sel) / `MULTI_SCALE;
  wire signed [31:0] m_rem = $signed(motor_rep_sel) % `MULTI_SCALE;

  // save sequence next state
  always @* begin
    next_save_state = save_state;
    case (save_state)
      ST_IDLE: begin
        if (save_go) begin
          next_save_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (i_flash_done) begin
          next_save_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_save_state = ST_DONE;   // only reset leaves this state
      end
      default: begin
        next_save_state = ST_IDLE;
      end
    endcase
  end

  // setup registers, status and save handling
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cfg_a           <= `CFG_A_RESET;
      cfg_b           <= `CFG_B_RESET;
      persist_prev    <= 1'b0;
      readback        <= 1'b0;
      save_state      <= ST_IDLE;
      flash_req       <= 1'b0;
      o_config_mode   <= 1'b0;
      o_cfg_error     <= 1'b0;
      o_locked        <= 1'b0;
      o_status_flash  <= 1'b0;
      o_last_word     <= `WORD_ZERO;
      o_in_word_a     <= `WORD_ZERO;
      o_in_word_b     <= `WORD_ZERO;
    end else begin
      save_state <= next_save_state;
      flash_req  <= save_go;
      if (i_out_valid) begin
        persist_prev <= i_setup_word_b[`CFG_B_PERSIST_BIT];
      end
      // readback latches on entry to config mode [RULE13]
      if (i_out_valid && !o_locked) begin
        if (!i_setup_word_a[`CFG_A_MODE_BIT]) begin
          readback      <= 1'b0;
          o_config_mode <= 1'b0;
        end else if (!o_config_mode && !readback &&
                     i_setup_word_b[`CFG_B_READBACK_BIT]) begin
          readback <= 1'b1;                                     // [RULE13]
        end else if (!i_setup_word_b[`CFG_B_READBACK_BIT]) begin
          readback <= 1'b0;
        end
      end
      // take or refuse new setup words
      if (take_new) begin
        if (new_valid) begin
          cfg_a         <= i_setup_word_a;
          cfg_b         <= i_setup_word_b;
          o_config_mode <= 1'b1;
          o_cfg_error   <= 1'b0;
        end else begin
          o_config_mode <= 1'b0;                                // [RULE25]
          o_cfg_error   <= 1'b1;                                // [RULE25]
        end
      end
      // mirrors show the held setup words
      o_in_word_a <= cfg_a;
      o_in_word_b <= cfg_b;
      // save outcome, then lock until reset
      if (save_state == ST_BUSY && i_flash_done) begin
        o_locked <= 1'b1;                                       // [RULE19]
        if (i_flash_ok) begin
          o_last_word    <= `PERSIST_OK;                        // [RULE17]
          o_status_flash <= 1'b1;                               // [RULE17]
        end else begin
          o_last_word <= `PERSIST_FAIL;                         // [RULE18]
        end
      end
    end
  end

  // decoded flags and input functions
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      act_prev         <= {N_INPUTS{1'b0}};
      captured         <= 32'h00000000;
      o_encoder_en     <= 1'b0;
      o_report_fmt32   <= 1'b0;
      o_command_fmt32  <= 1'b0;
      o_big_endian     <= 1'b0;
      o_gp_state       <= {N_INPUTS{1'b0}};
      o_cw_limit       <= 1'b0;
      o_ccw_limit      <= 1'b0;
      o_start_index    <= 1'b0;
      o_ctrl_stop      <= 1'b0;
      o_emergency_stop <= 1'b0;
      o_home_event     <= 1'b0;
    end else begin
      act_prev        <= act;
      o_encoder_en    <= cfg_a[`CFG_A_ENC_EN_BIT];              // [RULE1]
      o_report_fmt32  <= cfg_b[`CFG_B_REPORT_BIT];              // [RULE20]
      o_command_fmt32 <= cfg_b[`CFG_B_COMMAND_BIT];             // [RULE21]
      // order matters only when a 32-bit form is chosen
      o_big_endian    <= cfg_b[`CFG_B_ORDER_BIT] &
                         (cfg_b[`CFG_B_REPORT_BIT] |
                          cfg_b[`CFG_B_COMMAND_BIT]);           // [RULE22]
      // every input is reported whatever its function [RULE4]
      o_gp_state      <= act;
      o_cw_limit      <= |is_cw;
      o_ccw_limit     <= |is_ccw;
      // once locked, no command starts motion any more
      o_start_index    <= |go_index & ~o_locked;                // [RULE19]
      o_ctrl_stop      <= |go_stop;
      o_emergency_stop <= |go_estop;                            // [RULE8]
      o_home_event     <= |go_home;
      if (|cap_hit) begin
        captured <= i_encoder_pos;                              // [RULE6]
      end
    end
  end

  // packed report words and unpacked command value
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_motor_first  <= `WORD_ZERO;
      o_motor_second <= `WORD_ZERO;
      o_enc_first    <= `WORD_ZERO;
      o_enc_second   <= `WORD_ZERO;
      o_cap_first    <= `WORD_ZERO;
      o_cap_second   <= `WORD_ZERO;
      o_cmd_value    <= 32'h00000000;
    end else begin
      // slot 0 codec runs in command format, so motor packs here
      if (o_report_fmt32) begin
        o_motor_first  <= o_big_endian ? i_motor_pos[31:16]
                                       : i_motor_pos[15:0];     // [RULE24]
        o_motor_second <= o_big_endian ? i_motor_pos[15:0]
                                       : i_motor_pos[31:16];
      end else begin
        o_motor_first  <= m_quo[15:0];                          // [RULE23]
        o_motor_second <= m_rem[15:0];
      end
      o_enc_first  <= rep_first[1];                             // [RULE20]
      o_enc_second <= rep_second[1];
      o_cap_first  <= rep_first[2];
      o_cap_second <= rep_second[2];
      if (!o_locked) begin
        o_cmd_value <= cmd_unpacked;                            // [RULE21]
      end
    end
  end

endmodule
`default_nettype wire

// file: dv/motion_config_sva.sv
`timescale 1ns/10ps
`default_nettype none
// watches the decoder ports: save handshake, lock, pulses, setup refusal
module motion_config_sva (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  // host and flash side
  input wire logic        i_out_valid,
  input wire logic [15:0] i_setup_word_a,
  input wire logic [15:0] i_setup_word_b,
  input wire logic        i_flash_done,
  input wire logic        i_flash_ok,
  // decoder outputs
  input wire logic        o_flash_req,
  input wire logic        o_config_mode,
  input wire logic        o_cfg_error,
  input wire logic        o_encoder_en,
  input wire logic        o_report_fmt32,
  input wire logic        o_command_fmt32,
  input wire logic        o_big_endian,
  input wire logic        o_locked,
  input wire logic        o_status_flash,
  input wire logic        o_start_index,
  input wire logic        o_emergency_stop,
  input wire logic [15:0] o_in_word_a,
  input wire logic [15:0] o_in_word_b,
  input wire logic [15:0] o_last_word
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // flash finished well or badly before the lock
  sequence s_done_ok;
    i_flash_done && i_flash_ok && !o_locked;
  endsequence
  sequence s_done_bad;
    i_flash_done && !i_flash_ok && !o_locked;
  endsequence
  // a setup write carrying the reserved selector code
  sequence s_bad_sel;
    i_out_valid && i_setup_word_a[15] && !i_setup_word_b[11] &&
    !o_locked && (i_setup_word_a[2:0] == 3'h7 ||
    i_setup_word_a[5:3] == 3'h7);
  endsequence
  a_save_ok_code: assert property (s_done_ok |=>
    o_last_word == 16'hAAAA && o_status_flash && o_locked)
    else $error("save success code wrong");
  a_save_bad_code: assert property (s_done_bad |=>
    o_last_word == 16'hEEEE && o_locked)
    else $error("save failure code wrong");
  a_req_once: assert property (o_flash_req |=>
    !o_flash_req [*8]) else $error("flash request repeated");
  a_lock_hold: assert property (o_locked |=> o_locked &&
    $stable(o_last_word) && $stable(o_in_word_a))
    else $error("state moved after lock");
  a_index_lock: assert property (o_locked |-> !o_start_index)
    else $error("index start while locked");
  a_estop_once: assert property (o_emergency_stop |=>
    !o_emergency_stop) else $error("halt pulse too long");
  a_bad_sel: assert property (s_bad_sel |=>
    o_cfg_error && !o_config_mode) else $error("code 111 taken");
  a_flag_mirror: assert property (
    o_encoder_en == o_in_word_a[10] &&
    o_report_fmt32 == o_in_word_b[9] &&
    o_command_fmt32 == o_in_word_b[8]) else $error("flag vs mirror");
  a_order_gate: assert property (o_big_endian == (o_in_word_b[7] &&
    (o_in_word_b[9] || o_in_word_b[8]))) else $error("word order flag");
endmodule
bind motion_config_word_decoder motion_config_sva u_sva (
  .i_clk_sys, .i_rst_n, .i_out_valid, .i_setup_word_a, .i_setup_word_b,
  .i_flash_done, .i_flash_ok, .o_flash_req, .o_config_mode, .o_cfg_error,
  .o_encoder_en, .o_report_fmt32, .o_command_fmt32, .o_big_endian,
  .o_locked, .o_status_flash, .o_start_index, .o_emergency_stop,
  .o_in_word_a, .o_in_word_b, .o_last_word);
`default_nettype wire

// file: dv/flash_store_model.sv
`timescale 1ns/10ps
`default_nettype none
// flash store behind the decoder: answers a write after a set delay
module flash_store_model (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // request and scenario controls
  input  wire logic       i_req,
  input  wire logic       i_fail,   // next write fails
  input  wire logic [3:0] i_delay,  // extra cycles before done
  // answer
  output logic            o_done,
  output logic            o_ok
);
  logic [4:0] cnt;  // cycles left, 0 when idle
  // ok has meaning only with done, so show the wrong value otherwise
  assign o_ok = o_done ? !i_fail : i_fail;
  // count down from a request, then pulse done once
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt    <= 5'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 5'h01);
      if (i_req) begin
        cnt <= {1'b0, i_delay} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        i_clk_sys, i_rst_n, i_out_valid, i_homing, i_jog_active;
  logic [15:0] i_setup_word_a, i_setup_word_b, i_cmd_first, i_cmd_second;
  logic [1:0]  i_in_raw, o_gp_state;
  logic [31:0] i_motor_pos, i_encoder_pos, o_cmd_value;
  logic        o_flash_req, i_flash_done, i_flash_ok, fail_next;
  logic        o_config_mode, o_cfg_error, o_encoder_en, o_report_fmt32;
  logic        o_command_fmt32, o_big_endian, o_locked, o_status_flash;
  logic        o_cw_limit, o_start_index, o_ctrl_stop, o_emergency_stop;
  logic        o_home_event, o_ccw_limit;
  logic [15:0] o_in_word_b, o_enc_first, o_enc_second, o_cap_first;
  logic [15:0] o_in_word_a, o_last_word, o_motor_first, o_motor_second;
  logic [15:0] o_cap_second, c;
  int          miscompares, n_compared, cycles, n_req;
  motion_config_word_decoder u_dut (.i_clk_sys, .i_rst_n, .i_out_valid,
    .i_setup_word_a, .i_setup_word_b, .i_cmd_first, .i_cmd_second,
    .i_in_raw, .i_motor_pos, .i_encoder_pos, .i_homing, .i_jog_active,
    .o_flash_req, .i_flash_done, .i_flash_ok, .o_config_mode,
    .o_cfg_error, .o_encoder_en, .o_report_fmt32, .o_command_fmt32,
    .o_big_endian, .o_locked, .o_status_flash, .o_gp_state, .o_cw_limit,
    .o_ccw_limit, .o_start_index, .o_ctrl_stop, .o_emergency_stop,
    .o_home_event, .o_in_word_a, .o_in_word_b, .o_last_word,
    .o_motor_first, .o_motor_second, .o_enc_first, .o_enc_second,
    .o_cap_first, .o_cap_second, .o_cmd_value);
  flash_store_model u_flash (.i_clk_sys, .i_rst_n, .i_req(o_flash_req),
    .i_fail(fail_next), .i_delay(4'h3), .o_done(i_flash_done),
    .o_ok(i_flash_ok));
  // 50 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // cycle ceiling and flash request count
  always @(posedge i_clk_sys) begin
    cycles++;
    if (o_flash_req === 1'b1) n_req++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // reset held low for 12 cycles
  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
  endtask
  // one host write, then time for mirrors and flags to settle
  task automatic wr(input logic [15:0] a, b);
    @(posedge i_clk_sys);
    i_out_valid    <= 1'b1;
    i_setup_word_a <= a;
    i_setup_word_b <= b;
    @(posedge i_clk_sys);
    i_out_valid <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
  // move input n to level v, count pulses per kind, one nibble each
  task automatic edge_cnt(input int n, input logic v);
    c = 16'h0000;
    @(posedge i_clk_sys);
    i_in_raw[n] <= v;
    repeat (8) begin
      @(posedge i_clk_sys);
      #1;
      c = c + {3'h0, o_home_event, 3'h0, o_emergency_stop,
               3'h0, o_ctrl_stop, 3'h0, o_start_index};
    end
  endtask
  // setup decode, ignored bit 15, word order gate
  task automatic t_setup;
    chk({o_locked, o_config_mode, o_last_word}, 0);
    wr(16'h8419, 16'h8383);
    chk({o_config_mode, o_cfg_error, o_encoder_en}, 3'h5);
    chk({o_report_fmt32, o_command_fmt32, o_big_endian}, 3'h7);
    chk({o_in_word_a, o_in_word_b}, 32'h84198383);
    wr(16'h8419, 16'h0083);
    chk(o_big_endian, 1'b0);
  endtask
  // report and command words in each format
  task automatic t_formats;
    @(posedge i_clk_sys) i_motor_pos <= 32'd1234567;
    i_cmd_first  <= 16'h04D2;
    i_cmd_second <= 16'h0237;
    wr(16'h8419, 16'h0383);
    chk({o_motor_first, o_motor_second}, 32'h0012D687);
    wr(16'h8419, 16'h0303);
    chk({o_motor_first, o_motor_second}, 32'hD6870012);
    @(posedge i_clk_sys) i_motor_pos <= -32'sd7654321;
    wr(16'h8419, 16'h0003);
    chk({o_motor_first, o_motor_second}, 32'hE21AFEBF);
    chk(o_cmd_value, 32'd1234567);
    @(posedge i_clk_sys) i_cmd_first <= 16'hD687;
    i_cmd_second <= 16'h0012;
    wr(16'h8419, 16'h0103);
    chk(o_cmd_value, 32'd1234567);
  endtask
  // input functions: limit, index with capture, halt, stop, home
  task automatic t_inputs;
    wr(16'h8419, 16'h0003);
    @(posedge i_clk_sys) i_encoder_pos <= 32'd12;
    edge_cnt(0, 1'b1);
    chk({o_cw_limit, c}, 17'h10000);
    edge_cnt(1, 1'b1);
    chk({o_cap_first, o_cap_second, c}, 48'h0000000C0001);
    @(posedge i_clk_sys) i_encoder_pos <= -32'sd12;
    edge_cnt(1, 1'b0);
    chk({o_cap_second, c}, 32'hFFF40000);
    chk({o_enc_first, o_enc_second}, 32'h0000FFF4);
    edge_cnt(0, 1'b0);
    @(posedge i_clk_sys) i_in_raw <= 2'b01;
    wr(16'h8025, 16'h0002);
    edge_cnt(0, 1'b0);
    chk(c, 16'h0100);
    edge_cnt(1, 1'b1);
    chk(c, 16'h0000);
    @(posedge i_clk_sys) i_jog_active <= 1'b1;
    edge_cnt(1, 1'b0);
    edge_cnt(1, 1'b1);
    chk(c, 16'h0010);
    wr(16'h8006, 16'h0003);
    chk(o_gp_state, 2'b10);
    @(posedge i_clk_sys) i_homing <= 1'b1;
    edge_cnt(0, 1'b1);
    chk(c, 16'h1000);
    wr(16'h8016, 16'h0003);
    chk({o_ccw_limit, o_cw_limit}, 2'b10);
  endtask
  // refused setups, then readback
  task automatic t_refuse;
    logic [31:0] bad [4];
    bad = '{32'h80070003, 32'h80460003, 32'h80090003, 32'h80061003};
    foreach (bad[i]) begin
      wr(bad[i][31:16], bad[i][15:0]);
      chk({o_cfg_error, o_config_mode, o_in_word_a}, 18'h28016);
    end
    wr(16'h8419, 16'h0803);
    chk(o_in_word_a, 16'h8016);
    wr(16'h8419, 16'h0803);
    chk(o_in_word_a, 16'h8016);
    wr(16'h8419, 16'h0003);
    wr(16'h8419, 16'h0003);
    chk(o_in_word_a, 16'h8419);
  endtask
  // failed save locks the block; after reset a good save
  task automatic t_save;
    @(posedge i_clk_sys) fail_next <= 1'b1;
    wr(16'h8419, 16'h0407);
    chk(n_req, 0);
    wr(16'h8419, 16'h0003);
    wr(16'h8419, 16'h0403);
    repeat (10) @(posedge i_clk_sys);
    chk({o_last_word, o_locked, n_req[0]}, 18'h3BBBB);
    @(posedge i_clk_sys) i_cmd_first <= 16'h0001;
    wr(16'h8006, 16'h0003);
    chk({o_in_word_a, o_cmd_value}, 48'h8419FF5DFF6A);
    edge_cnt(1, 1'b0);
    edge_cnt(1, 1'b1);
    chk(c, 16'h0000);
    do_reset();
    fail_next <= 1'b0;
    wr(16'h8419, 16'h0003);
    wr(16'h8419, 16'h0403);
    repeat (10) @(posedge i_clk_sys);
    chk({o_last_word, o_status_flash, o_locked}, 18'h2AAAB);
    wr(16'h8419, 16'h0003);
    wr(16'h8419, 16'h0403);
    chk(n_req, 2);
  endtask
  initial begin
    {i_rst_n, i_out_valid, i_homing, i_jog_active, fail_next} <= 5'h00;
    {i_setup_word_a, i_setup_word_b, i_cmd_first, i_cmd_second} <= 64'h0;
    {i_in_raw, i_motor_pos, i_encoder_pos} <= 66'h0;
    {miscompares, n_compared, cycles, n_req} = 128'h0;
    @(posedge i_clk_sys);
    do_reset();
    t_setup();
    t_formats();
    t_inputs();
    t_refuse();
    t_save();
    wrap_up();
  end
endmodule
`default_nettype wire
